// *** sdh_irq_fifo_regs.sv ***
// Interrupt enable, status, FIFO counter and FIFO window registers
//
// Functional notes
// - IRQ when any flag meets its enable
// - Enables 5..0 gate error flags
// - Enables 10..6 gate completion flags
// - Enables 21..11 gate live FIFO flags
// - Enables 23,22 gate ATA and card flags
// - 24-bit read-only word counter, reset zero
// - Counter loads length/4, rounded up
// - Counter decrements once per cycle with any FIFO word move, holding at zero
// - FIFO window spans 0x80 to 0xFC
// - Write pushes transmit, read pops receive
// - Writing one clears a sticky flag
// - Bits 21..11 follow live hardware state
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module sdh_irq_fifo_regs
  import sdh_pkg::*;
#(
  parameter int FLAG_BITS = sdh_pkg::FLAG_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [sdh_pkg::ADDR_W-1:0] addr,
  input  wire logic [sdh_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [sdh_pkg::DATA_W-1:0] rdata,
  input  wire logic [FLAG_BITS-1:0]       event_set,
  input  wire logic [sdh_pkg::LIVE_W-1:0] live_flags,
  input  wire logic                      engine_word_move,
  output logic      [sdh_pkg::DATA_W-1:0] tx_word,
  output logic                           tx_push,
  input  wire logic [sdh_pkg::DATA_W-1:0] rx_word,
  output logic                           rx_pop,
  output logic      [sdh_pkg::LEN_W-1:0]  byte_length,
  output logic                           transfer_enable,
  output logic                           irq
);
  import sdh_pkg::*;

  // Registers
  logic [FLAG_BITS-1:0] enable_mask;
  logic [FLAG_BITS-1:0] sticky;
  logic [LIVE_W-1:0]    live_q1;
  logic [LIVE_W-1:0]    live_q2;
  logic [CNT_W-1:0]     words_remaining;

  // Address decode
  wire in_window  = (addr >= OFS_FIFO_BASE) && (addr <= OFS_FIFO_LAST);
  wire word_align = (addr[1:0] == 2'b00);
  wire sel_fifo   = in_window && word_align;
  wire sel_enable = (addr == OFS_IRQ_ENABLE);
  wire sel_count  = (addr == OFS_FIFO_COUNT);
  wire sel_clear  = (addr == OFS_FLAG_CLEAR);
  wire sel_status = (addr == OFS_STATUS);
  wire sel_len    = (addr == OFS_BYTE_LENGTH);
  wire sel_ctrl   = (addr == OFS_DATA_CTRL);

  wire wr_enable  = wr && sel_enable;
  wire wr_clear   = wr && sel_clear;
  wire wr_len     = wr && sel_len;
  wire wr_ctrl    = wr && sel_ctrl;
  wire fifo_wr    = wr && sel_fifo;
  wire fifo_rd    = rd && sel_fifo;

  // Counter loads on every control write with transfer enable set
  wire next_xfer_en = wdata[TRANSFER_EN_BIT];
  wire counter_load = wr_ctrl && next_xfer_en;
  // Software and engine moves count one word per cycle, even when both occur together
  wire word_move = fifo_wr || fifo_rd || engine_word_move;

  // Status view: sticky flags plus synchronised live flags
  wire [FLAG_BITS-1:0] live_view = FLAG_BITS'(live_q2) << LIVE_LSB;
  wire [FLAG_BITS-1:0] status_view = (sticky & STICKY_MASK) | live_view;

  // Set wins over clear for every sticky bit
  wire [FLAG_BITS-1:0] clear_bits = wr_clear ?
    (wdata[FLAG_BITS-1:0] & STICKY_MASK) : '0;
  wire [FLAG_BITS-1:0] next_sticky =
    ((sticky & ~clear_bits) | event_set) & STICKY_MASK;

  // Per-bit gating of each flag by its enable
  wire [FLAG_BITS-1:0] gated;
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_BITS; gi++) begin : g_gate
      assign gated[gi] = status_view[gi] & enable_mask[gi];
    end
  endgenerate
  wire next_irq = |gated;

  // Read mux, unmapped addresses answer zero
  logic [DATA_W-1:0] read_mux;
  always_comb begin
    read_mux = '0;
    if (sel_enable) begin
      read_mux = DATA_W'(enable_mask);
    end else if (sel_count) begin
      read_mux = DATA_W'(words_remaining);
    end else if (sel_status) begin
      read_mux = DATA_W'(status_view);
    end else if (sel_len) begin
      read_mux = DATA_W'(byte_length);
    end else if (sel_ctrl) begin
      read_mux = DATA_W'(transfer_enable);
    end else if (sel_fifo) begin
      read_mux = rx_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_mask <= ENABLE_RESET[FLAG_BITS-1:0];
    end else if (wr_enable) begin
      // Upper eight bits are simply not stored
      enable_mask <= wdata[FLAG_BITS-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sticky <= '0;
    end else begin
      sticky <= next_sticky;
    end
  end

  // Live conditions may come from another timing domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_q1 <= '0;
      live_q2 <= '0;
    end else begin
      live_q1 <= live_flags;
      live_q2 <= live_q1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byte_length <= '0;
    end else if (wr_len) begin
      byte_length <= wdata[LEN_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_enable <= 1'b0;
    end else if (wr_ctrl) begin
      transfer_enable <= next_xfer_en;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_word <= '0;
      tx_push <= 1'b0;
      rx_pop  <= 1'b0;
    end else begin
      tx_push <= fifo_wr;
      rx_pop  <= fifo_rd;
      if (fifo_wr) begin
        tx_word <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? read_mux : '0;
    end
  end

  // Registered so the pin never glitches on decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  sdh_word_counter #(
    .CNT_W (CNT_W),
    .LEN_W (LEN_W)
  ) u_counter (
    .clk             (clk),
    .rst             (rst),
    .load            (counter_load),
    .byte_length     (byte_length),
    .word_move       (word_move),
    .words_remaining (words_remaining)
  );
endmodule // sdh_irq_fifo_regs

// *** sdh_pkg.sv ***
// Register map, field layout and reset values of the register tail
package sdh_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          FLAG_W          = 24;
  localparam int          CNT_W           = 24;
  localparam int          LEN_W           = 25;
  localparam logic [7:0]  OFS_FLAG_CLEAR  = 8'h38;
  localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h3C;
  localparam logic [7:0]  OFS_FIFO_COUNT  = 8'h48;
  localparam logic [7:0]  OFS_FIFO_BASE   = 8'h80;
  localparam logic [7:0]  OFS_FIFO_LAST   = 8'hFC;
  localparam logic [7:0]  OFS_STATUS      = 8'h34;
  localparam logic [7:0]  OFS_BYTE_LENGTH = 8'h28;
  localparam logic [7:0]  OFS_DATA_CTRL   = 8'h2C;
  localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
  localparam logic [23:0] COUNT_RESET     = 24'h00_0000;
  localparam logic [23:0] STICKY_MASK     = 24'hC0_07FF;
  localparam logic [23:0] LIVE_MASK       = 24'h3F_F800;
  localparam int          LIVE_LSB        = 11;
  localparam int          LIVE_W          = 11;
  localparam int          TRANSFER_EN_BIT = 0;
endpackage

// *** sdh_word_counter.sv ***
// Remaining-word counter for the FIFO data transfer
`timescale 1ns/1ps
module sdh_word_counter #(
  parameter int CNT_W = 24,
  parameter int LEN_W = 25
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [LEN_W-1:0] byte_length,
  input  wire logic             word_move,
  output logic      [CNT_W-1:0] words_remaining
);
  import sdh_pkg::*;

  wire             partial = |byte_length[1:0];
  wire [CNT_W-1:0] words   = CNT_W'(byte_length[LEN_W-1:2]);
  wire [CNT_W-1:0] load_val = words + CNT_W'(partial);
  wire             can_dec = word_move && (words_remaining != '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      words_remaining <= COUNT_RESET;
    end else if (load) begin
      words_remaining <= load_val;
    end else if (can_dec) begin
      words_remaining <= words_remaining - CNT_W'(1);
    end
  end
endmodule // sdh_word_counter

// *** sdh_regs_checker.sv ***
// Bus-side assertions for the register tail
`timescale 1ns/1ps
module sdh_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [31:0] tx_word,
  input wire logic        tx_push,
  input wire logic        rx_pop
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Aligned window hit; unaligned offsets are refused
  wire w = addr[7] && addr[1:0] == 2'h0;
  chk_tx_push: assert property (wr && w |=> tx_push
    && tx_word == $past(wdata)) else $error("push lost");
  chk_rx_pop: assert property (rd && w |=> rx_pop)
    else $error("pop lost");
  chk_push_cause: assert property (!(wr && w) |=> !tx_push)
    else $error("stray push");
  chk_pop_cause: assert property (!(rd && w) |=> !rx_pop)
    else $error("stray pop");
  chk_read_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("stray read data");
  chk_count_top: assert property (rd && addr == 8'h48 |=>
    rdata[31:24] == 8'h00) else $error("count top set");
  chk_enable_top: assert property (rd && addr == 8'h3C |=>
    rdata[31:24] == 8'h00) else $error("enable top set");
  chk_enable_back: assert property (wr && addr == 8'h3C ##2
    rd && addr == 8'h3C |=> rdata[23:0] == $past(wdata[23:0], 3))
    else $error("enable readback");
endmodule // sdh_regs_checker
bind sdh_irq_fifo_regs sdh_regs_checker chk_u (.clk, .rst, .addr,
  .wdata, .wr, .rd, .rdata, .tx_word, .tx_push, .rx_pop);

// *** sdh_irq_fifo_regs_tb.sv ***
// Self-checking bench for the register tail
`timescale 1ns/1ps
module sdh_irq_fifo_regs_tb;
  import sdh_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, mv = 0, te, irq;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rx_word = 0, rdata, b, tw;
  logic [23:0] event_set = 0;
  logic [10:0] live = 0;
  logic [24:0] len, bl;
  int          fail_count = 0, compares = 0;
  always #20 clk = ~clk;
  sdh_irq_fifo_regs dut_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .event_set, .live_flags(live), .engine_word_move(mv), .tx_word(tw),
    .tx_push(), .rx_word, .rx_pop(), .byte_length(bl), .transfer_enable(te),
    .irq);
  task automatic eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("wrong value at %0t: %h", $time, got);
  endtask
  task automatic wr_reg(input logic [7:0] x, input logic [31:0] d);
    addr <= x;
    // Whole words only, callers keep bits 31:24 of enable and count zero
    wdata <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
    // Gap so a following write never re-raises wr in this time step
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] x, input logic [31:0] d);
    addr <= x;
    rd <= 1;
    @(posedge clk) rd <= 0;
    #1 eq(rdata, d);
    @(posedge clk);
  endtask
  task automatic irq_is(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1 eq(32'(irq), 32'(e));
    @(posedge clk);
  endtask
  task automatic t_irq;
    rd_reg(OFS_IRQ_ENABLE, ENABLE_RESET);
    rd_reg(OFS_FIFO_COUNT, 32'h0);
    for (int i = 0; i < 24; i++) begin
      b = 32'h1 << i;
      wr_reg(OFS_IRQ_ENABLE, b);
      event_set <= b[23:0] & STICKY_MASK;
      live <= b[21:11];
      @(posedge clk) event_set <= 0;
      irq_is(4, 1);
      wr_reg(OFS_FLAG_CLEAR, ~b & 32'hFF_FFFF);
      irq_is(2, 1);
      wr_reg(OFS_IRQ_ENABLE, ~b & 32'hFF_FFFF);
      irq_is(2, 0);
      wr_reg(OFS_FLAG_CLEAR, 32'hFF_FFFF);
      wr_reg(OFS_IRQ_ENABLE, b);
      irq_is(2, LIVE_MASK[i]);
      live <= 0;
      irq_is(5, 0);
    end
    $display("irq test done");
  endtask
  task automatic t_data;
    wr_reg(OFS_FIFO_LAST, 32'hA5C3);
    eq(tw, 32'hA5C3);
    rx_word <= 32'h5A3C;
    rd_reg(OFS_FIFO_BASE, 32'h5A3C);
    wr_reg(OFS_IRQ_ENABLE, 32'h00FF_FFFF);
    rd_reg(OFS_IRQ_ENABLE, 32'hFF_FFFF);
    wr_reg(OFS_IRQ_ENABLE, 32'h0);
    for (int i = 0; i < 2; i++) begin
      len = i ? 25'h13 : 25'h1FF_FFFF;
      wr_reg(OFS_BYTE_LENGTH, 32'(len));
      eq(32'(bl), 32'(len));
      wr_reg(OFS_DATA_CTRL, 32'h1);
      rd_reg(OFS_FIFO_COUNT, 32'(len[24:2]) + 32'(|len[1:0]));
    end
    // Read-only counter must ignore this write
    wr_reg(OFS_FIFO_COUNT, 32'h00FF_FFFF);
    wr_reg(OFS_FIFO_BASE, 32'h0);
    mv <= 1;
    @(posedge clk) mv <= 0;
    rd_reg(OFS_FIFO_LAST, 32'h5A3C);
    rd_reg(OFS_FIFO_COUNT, 32'h2);
    eq(32'(te), 32'h1);
    $display("data test done");
  endtask
  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_irq;
    t_data;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule // sdh_irq_fifo_regs_tb
